// ---- shared/iic_regs.svh ----
// Constants of the IEEE-488 interface control block: timing, bus codes, register map.
// Included by the package and the design modules; holds definitions only.
`ifndef IIC_REGS_SVH
`define IIC_REGS_SVH

// Timing, system clock 100 MHz
`define IIC_CLK_NS 10
`define IIC_T1M_NS 1000
`define IIC_T5M_NS 200
`define IIC_DIV_1M (`IIC_T1M_NS / `IIC_CLK_NS)
`define IIC_DIV_5M (`IIC_T5M_NS / `IIC_CLK_NS)

// Bus commands and address groups (logic levels, after inversion)
`define IIC_CMD_DCL 8'h14
`define IIC_CMD_SDC 8'h04
`define IIC_CMD_GET 8'h08
`define IIC_CMD_SPE 8'h18
`define IIC_CMD_SPD 8'h19
`define IIC_CMD_UNL 8'h3F
`define IIC_CMD_UNT 8'h5F
`define IIC_GRP_LISTEN 2'h1
`define IIC_GRP_TALK 2'h2

// Program codes on data bytes
`define IIC_PC_MANT 8'h4D
`define IIC_PC_DEAD 8'h44
`define IIC_PC_EXP 8'h45
`define IIC_PC_TRIG 8'h47
`define IIC_PC_COUNT 8'h4E
`define IIC_PC_DIGIT 8'h54
`define IIC_PC_CLEAR 8'h52
`define IIC_PC_HALT 8'h48
`define IIC_DIGIT_HI 4'h3

// Switch bits
`define IIC_SW_TRIG_LVL 5
`define IIC_SW_TALK_ALWAYS 6

// Memory fill codes
`define IIC_FILL_FULL 2'h3

// APB register map
`define IIC_A_CTRL 12'h000
`define IIC_A_STAT 12'h004
`define IIC_A_RXD 12'h008
`define IIC_CTRL_HOLD 0
`define IIC_CTRL_STCLR 1

`endif

// ---- shared/iic_pkg.sv ----
// Types shared by the interface control block modules.
// Assumes iic_regs.svh is on the include path.
`include "iic_regs.svh"
package iic_pkg;

  typedef enum logic [1:0] {IIC_LH_READY, IIC_LH_ACCEPT} iic_lh_e;
  typedef enum logic [1:0] {IIC_SH_IDLE, IIC_SH_SETTLE, IIC_SH_WAIT} iic_sh_e;
  typedef enum logic [2:0] {
    IIC_T_NONE, IIC_T_MANT, IIC_T_DEAD, IIC_T_EXP, IIC_T_TRIG, IIC_T_COUNT, IIC_T_DIGIT
  } iic_tgt_e;

  typedef struct packed {
    logic [6:0] cnt1m;
    logic [4:0] cnt5m;
    iic_lh_e lh;
    iic_sh_e sh;
    logic talk;
    logic listen;
    logic spa;
    logic [3:0] latch;
    logic rx_evt;
    logic rx_atn;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic tx_status;
    logic mem_ready;
    logic ctrl_hold;
    logic [31:0] prdata;
  } iic_top_s;

  typedef struct packed {
    iic_tgt_e tgt;
    iic_tgt_e strobe;
    logic pend;
    logic [7:0] pdl;
    logic diag_wr;
    logic mant_clr;
    logic count_clr;
    logic digit_clr;
    logic gate_clr;
    logic acc_stop;
    logic get_evt;
    logic dcl_evt;
    logic spe_evt;
    logic spd_evt;
  } iic_dec_s;

endpackage

// ---- shared/iic_dec_if.sv ----
// Link between the interface control top and its program code decoder.
// Single clock domain; all signals are clk_sys synchronous.
`timescale 1ns/10ps
interface iic_dec_if;
  logic preset;
  logic tick1m;
  logic rx_evt;
  logic rx_atn;
  logic [7:0] rx_byte;
  logic listen;
  logic [7:0] pdl;
  logic [5:0] load_strobe;
  logic mant_clr;
  logic count_clr;
  logic digit_clr;
  logic gate_clr;
  logic acc_stop;
  logic diag_wr;
  logic get_evt;
  logic dcl_evt;
  logic spe_evt;
  logic spd_evt;

  modport top (
    output preset, tick1m, rx_evt, rx_atn, rx_byte, listen,
    input pdl, load_strobe, mant_clr, count_clr, digit_clr, gate_clr, acc_stop,
    input diag_wr, get_evt, dcl_evt, spe_evt, spd_evt
  );
  modport dec (
    input preset, tick1m, rx_evt, rx_atn, rx_byte, listen,
    output pdl, load_strobe, mant_clr, count_clr, digit_clr, gate_clr, acc_stop,
    output diag_wr, get_evt, dcl_evt, spe_evt, spd_evt
  );
endinterface

// ---- rtl/iic_decode.sv ----
// Program code and bus command decoder of the interface control block.
// Fed with accepted bus bytes by iic_top; one clock, synchronous preset.
`timescale 1ns/10ps
`include "iic_regs.svh"
module iic_decode (
  input wire logic clk_sys,
  input wire logic rst_n,
  iic_dec_if.dec d
);
  import iic_pkg::*;

  iic_dec_s s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.diag_wr = 1'b0;
    s_nxt.mant_clr = 1'b0;
    s_nxt.count_clr = 1'b0;
    s_nxt.digit_clr = 1'b0;
    s_nxt.gate_clr = 1'b0;
    s_nxt.acc_stop = 1'b0;
    s_nxt.get_evt = 1'b0;
    s_nxt.dcl_evt = 1'b0;
    s_nxt.spe_evt = 1'b0;
    s_nxt.spd_evt = 1'b0;
    // Strobe opens one tick after the value is set and lasts one tick
    if (d.tick1m) begin
      s_nxt.strobe = s_r.pend ? s_r.tgt : IIC_T_NONE;
      s_nxt.pend = 1'b0;
    end
    if (d.rx_evt) begin
      if (d.rx_atn) begin
        // DCL, SPE and SPD are seen by every device, addressed or not; SDC and GET only by a listener
        if (d.rx_byte == `IIC_CMD_DCL || (d.rx_byte == `IIC_CMD_SDC && d.listen)) begin
          s_nxt.dcl_evt = 1'b1;
          s_nxt.mant_clr = 1'b1;
          s_nxt.count_clr = 1'b1;
          s_nxt.digit_clr = 1'b1;
          s_nxt.gate_clr = 1'b1;
          s_nxt.acc_stop = 1'b1;
          s_nxt.tgt = IIC_T_NONE;
          s_nxt.pend = 1'b0;
        end
        s_nxt.get_evt = d.listen && d.rx_byte == `IIC_CMD_GET;
        s_nxt.spe_evt = d.rx_byte == `IIC_CMD_SPE;
        s_nxt.spd_evt = d.rx_byte == `IIC_CMD_SPD;
      end else if (d.listen) begin
        if (d.rx_byte[7:4] == `IIC_DIGIT_HI && s_r.tgt != IIC_T_NONE) begin
          // Only the low nibble means anything for a code
          s_nxt.pdl = {4'h0, d.rx_byte[3:0]};
          s_nxt.pend = 1'b1;
        end else begin
          case (d.rx_byte)
            `IIC_PC_MANT: s_nxt.tgt = IIC_T_MANT;
            `IIC_PC_DEAD: s_nxt.tgt = IIC_T_DEAD;
            `IIC_PC_EXP: s_nxt.tgt = IIC_T_EXP;
            `IIC_PC_TRIG: s_nxt.tgt = IIC_T_TRIG;
            `IIC_PC_COUNT: s_nxt.tgt = IIC_T_COUNT;
            `IIC_PC_DIGIT: s_nxt.tgt = IIC_T_DIGIT;
            `IIC_PC_CLEAR: begin
              s_nxt.tgt = IIC_T_NONE;
              s_nxt.mant_clr = 1'b1;
              s_nxt.count_clr = 1'b1;
              s_nxt.digit_clr = 1'b1;
              s_nxt.gate_clr = 1'b1;
              s_nxt.acc_stop = 1'b1;
            end
            `IIC_PC_HALT: begin
              s_nxt.tgt = IIC_T_NONE;
              s_nxt.acc_stop = 1'b1;
            end
            default: begin
              // Any other byte is diagnostic data for memory
              s_nxt.tgt = IIC_T_NONE;
              s_nxt.pdl = d.rx_byte;
              s_nxt.diag_wr = 1'b1;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || d.preset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign d.pdl = s_r.pdl;
  assign d.load_strobe = {s_r.strobe == IIC_T_DIGIT, s_r.strobe == IIC_T_COUNT,
    s_r.strobe == IIC_T_TRIG, s_r.strobe == IIC_T_EXP, s_r.strobe == IIC_T_DEAD,
    s_r.strobe == IIC_T_MANT};
  assign d.mant_clr = s_r.mant_clr;
  assign d.count_clr = s_r.count_clr;
  assign d.digit_clr = s_r.digit_clr;
  assign d.gate_clr = s_r.gate_clr;
  assign d.acc_stop = s_r.acc_stop;
  assign d.diag_wr = s_r.diag_wr;
  assign d.get_evt = s_r.get_evt;
  assign d.dcl_evt = s_r.dcl_evt;
  assign d.spe_evt = s_r.spe_evt;
  assign d.spd_evt = s_r.spd_evt;
endmodule

// ---- rtl/iic_top.sv ----
// IEEE-488 interface control: addressing, handshakes, status latch, serial poll, APB.
// Bus pins are active low and open drain; memory, gate and system control sit outside.
//
// Behaviour
// - Address match sets talk or listen flag
// - Lowest switch bit excluded from compare
// - Talk-always switch makes device talk unaddressed
// - Sixth switch bit selects trigger threshold
// - Detect DCL, SDC, GET, SPE, SPD
// - Program codes give per-register load strobes
// - Clear codes give clears, gate_clear, accumulate_stop
// - Eight data lines; codes use lowest four
// - Listen handshake on 1 MHz, held off
// - Accumulating stops accepting bus data bytes
// - Source handshake sends memory or status
// - Status latch captures four conditions
// - Latched condition raises service request
// - Serial poll sends status byte instead
// - B1 power, B2 dead time, B3 sync
// - B4 B5 encode memory fill level
// - Interface timed by 1 and 5 MHz
// - Status latch clears after status read
// - Power-up preset forces defined state
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`include "iic_regs.svh"
module iic_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_up_preset,
  input wire logic [6:0] addr_switch,
  input wire logic [7:0] dio_n_in,
  output logic [7:0] dio_n_out,
  output logic dio_n_oe,
  input wire logic atn_n_in,
  input wire logic dav_n_in,
  output logic dav_n_out,
  output logic dav_n_oe,
  input wire logic nrfd_n_in,
  output logic nrfd_n_out,
  output logic nrfd_n_oe,
  input wire logic ndac_n_in,
  output logic ndac_n_out,
  output logic ndac_n_oe,
  output logic srq_n_out,
  output logic srq_n_oe,
  input wire logic [7:0] mem_data,
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [1:0] mem_fill,
  input wire logic accumulating_flag,
  input wire logic dead_time_overrun,
  input wire logic sync_error_full,
  input wire logic count_done,
  input wire logic power_fail,
  output logic [7:0] programmed_data_lines,
  output logic mantissa_load_strobe,
  output logic dead_time_load_strobe,
  output logic exponent_load_strobe,
  output logic trigger_mode_load_strobe,
  output logic count_load_strobe,
  output logic digit_count_load_strobe,
  output logic mantissa_clear,
  output logic count_clear,
  output logic digit_count_clear,
  output logic gate_clear,
  output logic accumulate_stop,
  output logic diag_write_strobe,
  output logic group_trigger,
  output logic device_clear,
  output logic trig_level_4v,
  output logic service_request_out,
  output logic serial_poll_active,
  output logic talk_ind,
  output logic listen_ind,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import iic_pkg::*;

  iic_top_s s_r, s_nxt;
  iic_dec_if dif ();

  logic [7:0] dio;
  logic atn;
  logic dav;
  logic tick1m;
  logic tick5m;
  logic talk_always;
  logic participate;
  logic hold;
  logic talker_active;
  logic srq;
  logic [7:0] status_byte;
  logic apb_wr;
  logic apb_setup;
  logic mapped;

  // Bus lines are active low
  assign dio = ~dio_n_in;
  assign atn = ~atn_n_in;
  assign dav = ~dav_n_in;

  // Both dividers start together, so every 1 MHz tick is also a 5 MHz tick
  assign tick1m = s_r.cnt1m == 7'(`IIC_DIV_1M - 1);
  assign tick5m = s_r.cnt5m == 5'(`IIC_DIV_5M - 1);

  assign talk_always = addr_switch[`IIC_SW_TALK_ALWAYS];
  assign trig_level_4v = addr_switch[`IIC_SW_TRIG_LVL];

  // Commands under ATN always handshaken; data only when addressed
  assign participate = atn || s_r.listen;
  assign hold = !atn && (accumulating_flag || mem_fill == `IIC_FILL_FULL
    || s_r.ctrl_hold);
  assign talker_active = (s_r.talk || talk_always) && !atn;

  assign srq = |s_r.latch;
  assign status_byte = {1'b0, srq, s_r.latch[3], mem_fill[0], mem_fill[1],
    s_r.latch[2], s_r.latch[1], s_r.latch[0]};

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign mapped = paddr == `IIC_A_CTRL || paddr == `IIC_A_STAT || paddr == `IIC_A_RXD;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_evt = 1'b0;
    s_nxt.mem_ready = 1'b0;
    s_nxt.cnt1m = tick1m ? 7'h00 : s_r.cnt1m + 7'h01;
    s_nxt.cnt5m = tick5m ? 5'h00 : s_r.cnt5m + 5'h01;

    // Listen handshake, paced by the 1 MHz tick
    case (s_r.lh)
      IIC_LH_READY: begin
        if (tick1m && participate && dav && !hold) begin
          s_nxt.rx_byte = dio;
          s_nxt.rx_atn = atn;
          s_nxt.rx_evt = 1'b1;
          s_nxt.lh = IIC_LH_ACCEPT;
        end
      end
      IIC_LH_ACCEPT: begin
        if (tick1m && !dav) begin
          s_nxt.lh = IIC_LH_READY;
        end
      end
      default: s_nxt.lh = IIC_LH_READY;
    endcase

    // Address flags move on the 5 MHz tick that samples the byte
    if (tick5m && s_r.lh == IIC_LH_READY && tick1m && participate && dav && !hold && atn) begin
      if (dio[6:5] == `IIC_GRP_LISTEN && dio[4:1] == addr_switch[4:1]) begin
        s_nxt.listen = 1'b1;
      end
      if (dio[6:5] == `IIC_GRP_TALK) begin
        s_nxt.talk = dio[4:1] == addr_switch[4:1];
      end
      if (dio == `IIC_CMD_UNL) begin
        s_nxt.listen = 1'b0;
      end
      if (dio == `IIC_CMD_UNT) begin
        s_nxt.talk = 1'b0;
      end
    end

    if (dif.spe_evt) begin
      s_nxt.spa = 1'b1;
    end
    if (dif.spd_evt) begin
      s_nxt.spa = 1'b0;
    end

    // Source handshake
    case (s_r.sh)
      IIC_SH_IDLE: begin
        if (tick1m && talker_active && (s_r.spa || mem_valid)) begin
          s_nxt.tx_byte = s_r.spa ? status_byte : mem_data;
          s_nxt.tx_status = s_r.spa;
          s_nxt.sh = IIC_SH_SETTLE;
        end
      end
      IIC_SH_SETTLE: begin
        // Data lines settle for at least one tick before DAV
        if (tick1m && nrfd_n_in) begin
          s_nxt.sh = IIC_SH_WAIT;
        end
      end
      IIC_SH_WAIT: begin
        if (tick1m && ndac_n_in) begin
          s_nxt.sh = IIC_SH_IDLE;
          s_nxt.mem_ready = !s_r.tx_status;
        end
      end
      default: s_nxt.sh = IIC_SH_IDLE;
    endcase
    if (!talker_active) begin
      s_nxt.sh = IIC_SH_IDLE;
    end

    // Sticky status: a new event wins over the clear
    s_nxt.latch = s_r.latch;
    if ((s_r.sh == IIC_SH_WAIT && tick1m && ndac_n_in && s_r.tx_status)
        || (apb_wr && paddr == `IIC_A_CTRL && pwdata[`IIC_CTRL_STCLR])) begin
      s_nxt.latch = 4'h0;
    end
    s_nxt.latch = s_nxt.latch | {count_done, sync_error_full, dead_time_overrun,
      power_fail};

    if (dif.dcl_evt) begin
      s_nxt.spa = 1'b0;
    end

    // APB: zero wait states, read data latched in the setup cycle
    if (apb_wr && paddr == `IIC_A_CTRL) begin
      s_nxt.ctrl_hold = pwdata[`IIC_CTRL_HOLD];
    end
    if (apb_setup) begin
      case (paddr)
        `IIC_A_CTRL: s_nxt.prdata = {31'h0000_0000, s_r.ctrl_hold};
        `IIC_A_STAT: s_nxt.prdata = {22'h00_0000, talk_always, s_r.spa, s_r.listen,
          s_r.talk, mem_fill, s_r.latch};
        `IIC_A_RXD: s_nxt.prdata = {24'h00_0000, s_r.rx_byte};
        default: s_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || power_up_preset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dif.preset = power_up_preset;
  assign dif.tick1m = tick1m;
  assign dif.rx_evt = s_r.rx_evt;
  assign dif.rx_atn = s_r.rx_atn;
  assign dif.rx_byte = s_r.rx_byte;
  assign dif.listen = s_r.listen;

  iic_decode u_decode (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(dif.dec)
  );

  // Open-drain lines: enable pulls low
  assign nrfd_n_out = 1'b0;
  assign ndac_n_out = 1'b0;
  assign dav_n_out = 1'b0;
  assign srq_n_out = 1'b0;
  assign nrfd_n_oe = participate && (s_r.lh == IIC_LH_ACCEPT || hold);
  assign ndac_n_oe = participate && s_r.lh == IIC_LH_READY;
  assign dio_n_out = ~s_r.tx_byte;
  assign dio_n_oe = s_r.sh != IIC_SH_IDLE;
  assign dav_n_oe = s_r.sh == IIC_SH_WAIT;
  assign srq_n_oe = srq;

  assign mem_ready = s_r.mem_ready;
  assign service_request_out = srq;
  assign serial_poll_active = s_r.spa;
  assign talk_ind = s_r.talk || talk_always;
  assign listen_ind = s_r.listen;

  assign programmed_data_lines = dif.pdl;
  assign mantissa_load_strobe = dif.load_strobe[0];
  assign dead_time_load_strobe = dif.load_strobe[1];
  assign exponent_load_strobe = dif.load_strobe[2];
  assign trigger_mode_load_strobe = dif.load_strobe[3];
  assign count_load_strobe = dif.load_strobe[4];
  assign digit_count_load_strobe = dif.load_strobe[5];
  assign mantissa_clear = dif.mant_clr;
  assign count_clear = dif.count_clr;
  assign digit_count_clear = dif.digit_clr;
  assign gate_clear = dif.gate_clr;
  assign accumulate_stop = dif.acc_stop;
  assign diag_write_strobe = dif.diag_wr;
  assign group_trigger = dif.get_evt;
  assign device_clear = dif.dcl_evt;

  assign prdata = s_r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
endmodule

// ---- tb/iic_monitor.sv ----
// Checker of the interface control top: strobes, service request, hold-off.
// Sees iic_top ports only; attached by the bind below.
`timescale 1ns/10ps
module iic_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_up_preset,
  input wire logic [6:0] addr_switch,
  input wire logic atn_n_in,
  input wire logic accumulating_flag,
  input wire logic [1:0] mem_fill,
  input wire logic power_fail,
  input wire logic dio_n_oe,
  input wire logic dav_n_oe,
  input wire logic nrfd_n_oe,
  input wire logic mem_ready,
  input wire logic mantissa_load_strobe,
  input wire logic dead_time_load_strobe,
  input wire logic exponent_load_strobe,
  input wire logic trigger_mode_load_strobe,
  input wire logic count_load_strobe,
  input wire logic digit_count_load_strobe,
  input wire logic trig_level_4v,
  input wire logic service_request_out,
  input wire logic serial_poll_active,
  input wire logic talk_ind,
  input wire logic listen_ind
);
  logic [5:0] stb;
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  assign stb = {digit_count_load_strobe, count_load_strobe, trigger_mode_load_strobe,
    exponent_load_strobe, dead_time_load_strobe, mantissa_load_strobe};
  // Length of the current strobe run, in system clocks
  always_comb run_nxt = (stb != 6'h00) ? run_r + 8'h01 : 8'h00;
  always_ff @(posedge clk_sys) run_r <= rst_n ? run_nxt : 8'h00;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  strobe_onehot_a: assert property ($onehot0(stb)) else $error("two load strobes");
  strobe_max_a: assert property (stb != 6'h00 |-> run_r < 8'h64)
    else $error("load strobe too long");
  strobe_len_a: assert property ($fell(stb != 6'h00) |-> run_r == 8'h64)
    else $error("load strobe length wrong");
  srq_set_a: assert property (power_fail |=> service_request_out)
    else $error("service request missing");
  trig_level_a: assert property (trig_level_4v == addr_switch[5])
    else $error("trigger level wrong");
  talk_always_a: assert property (addr_switch[6] |-> talk_ind)
    else $error("talk always ignored");
  data_valid_a: assert property (dav_n_oe |-> dio_n_oe)
    else $error("data valid without data");
  accumulating_flag_hold_a: assert property (listen_ind && atn_n_in && accumulating_flag |-> nrfd_n_oe)
    else $error("byte accepted while accumulating");
  full_hold_a: assert property (listen_ind && atn_n_in && mem_fill == 2'h3 |-> nrfd_n_oe)
    else $error("byte accepted while full");
  mem_ready_a: assert property (mem_ready |-> $past(dav_n_oe) && !serial_poll_active)
    else $error("memory byte consumed unsent");
  preset_a: assert property (power_up_preset |=> !listen_ind && !serial_poll_active)
    else $error("preset state wrong");
endmodule
bind iic_top iic_monitor u_mon (.clk_sys, .rst_n, .power_up_preset, .addr_switch, .atn_n_in,
  .accumulating_flag, .mem_fill, .power_fail, .dio_n_oe, .dav_n_oe, .nrfd_n_oe, .mem_ready,
  .mantissa_load_strobe, .dead_time_load_strobe, .exponent_load_strobe,
  .trigger_mode_load_strobe, .count_load_strobe, .digit_count_load_strobe, .trig_level_4v,
  .service_request_out, .serial_poll_active, .talk_ind, .listen_ind);

// ---- tb/iic_ctl_model.sv ----
// Bus controller model: three-wire handshake as talker and as acceptor.
// Assumes the bench forms the wired bus levels from both parties.
`timescale 1ns/10ps
module iic_ctl_model (
  input wire logic clk_sys,
  input wire logic [7:0] dio_n_in,
  input wire logic dav_n_in,
  input wire logic nrfd_n_in,
  input wire logic ndac_n_in,
  output logic atn_n_in,
  output logic [7:0] c_dio_n,
  output logic c_dav_n,
  output logic c_nrfd_n,
  output logic c_ndac_n
);
  initial begin
    atn_n_in = 1'b1;
    c_dio_n = 8'hff;
    c_dav_n = 1'b1;
    c_nrfd_n = 1'b1;
    c_ndac_n = 1'b1;
  end
  // Falling-edge sampling sees settled levels; bounded so a dead device ends it
  task automatic wait_for(input int sel, input logic lvl, output logic hit);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
      hit = (sel == 0) ? nrfd_n_in : (sel == 1) ? ndac_n_in : dav_n_in;
    end while (hit !== lvl && i < 2000);
    hit = (hit === lvl);
  endtask
  task automatic send(input logic atn, input logic [7:0] b, output logic ok);
    logic hit;
    ok = 1'b0;
    @(posedge clk_sys);
    atn_n_in <= ~atn;
    c_dio_n <= ~b;
    c_nrfd_n <= 1'b1;
    c_ndac_n <= 1'b1;
    wait_for(0, 1'b1, hit);
    if (hit) begin
      @(posedge clk_sys);
      c_dav_n <= 1'b0;
      wait_for(1, 1'b1, ok);
    end
    @(posedge clk_sys);
    c_dav_n <= 1'b1;
    // Released lines float high through the terminators
    c_dio_n <= 8'hff;
  endtask
  task automatic recv(input int dly, output logic [7:0] b, output logic ok);
    logic hit;
    @(posedge clk_sys);
    atn_n_in <= 1'b1;
    c_ndac_n <= 1'b0;
    c_nrfd_n <= 1'b0;
    repeat (dly + 1) @(posedge clk_sys);
    c_nrfd_n <= 1'b1;
    wait_for(2, 1'b0, ok);
    b = ~dio_n_in;
    @(posedge clk_sys);
    c_nrfd_n <= 1'b0;
    @(posedge clk_sys);
    c_ndac_n <= 1'b1;
    wait_for(2, 1'b1, hit);
    @(posedge clk_sys);
    c_ndac_n <= 1'b0;
  endtask
endmodule

// ---- tb/ieee488_interface_control_tb.sv ----
// Self-checking bench of the interface control top with a bus controller model.
// Assumes iic_regs.svh on the include path; the checker binds itself to iic_top.
`timescale 1ns/10ps
`include "iic_regs.svh"
module ieee488_interface_control_tb;
  logic clk_sys, rst_n, power_up_preset, atn_n_in, dav_n_in, nrfd_n_in, ndac_n_in;
  logic [6:0] addr_switch;
  logic [7:0] dio_n_in, dio_n_out, mem_data, programmed_data_lines, c_dio_n, v, b;
  logic dio_n_oe, dav_n_out, dav_n_oe, nrfd_n_out, nrfd_n_oe, ndac_n_out, ndac_n_oe;
  logic srq_n_out, srq_n_oe, mem_valid, mem_ready, accumulating_flag, dead_time_overrun;
  logic sync_error_full, count_done, power_fail, mantissa_load_strobe, dead_time_load_strobe;
  logic exponent_load_strobe, trigger_mode_load_strobe, count_load_strobe;
  logic digit_count_load_strobe, mantissa_clear, count_clear, digit_count_clear, gate_clear;
  logic accumulate_stop, diag_write_strobe, group_trigger, device_clear, trig_level_4v;
  logic service_request_out, serial_poll_active, talk_ind, listen_ind;
  logic psel, penable, pwrite, pready, pslverr, err, ok, clr_seen, c_dav_n, c_nrfd_n, c_ndac_n;
  logic [1:0] mem_fill, fill0;
  logic [3:0] lat;
  logic [5:0] stb;
  logic [8:0] seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] cmd [6];
  logic [8:0] want [6];
  logic [7:0] codes [6];
  int n_errors, checks_done, cyc, k;
  iic_top dut (.*);
  iic_ctl_model ctl (.*);
  assign dio_n_in = c_dio_n & (dio_n_oe ? dio_n_out : 8'hff);
  assign dav_n_in = c_dav_n & (dav_n_oe ? dav_n_out : 1'b1);
  assign nrfd_n_in = c_nrfd_n & (nrfd_n_oe ? nrfd_n_out : 1'b1);
  assign ndac_n_in = c_ndac_n & (ndac_n_oe ? ndac_n_out : 1'b1);
  assign stb = {digit_count_load_strobe, count_load_strobe, trigger_mode_load_strobe,
    exponent_load_strobe, dead_time_load_strobe, mantissa_load_strobe};
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Sticky record of one-clock pulses, cleared by the sequence
  always @(posedge clk_sys) begin
    seen <= clr_seen ? 9'h000 : seen | {diag_write_strobe, mantissa_clear, count_clear,
      digit_count_clear, gate_clear, accumulate_stop, group_trigger, device_clear, mem_ready};
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_stb(input int idx);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (stb == 6'h00 && i < 400);
    chk(stb, 6'h01 << idx);
    i = 0;
    while (stb != 6'h00 && i < 300) begin
      @(negedge clk_sys);
      i++;
    end
    chk(i, 32'h0000_0064);
  endtask
  function automatic logic [7:0] sbyte(input logic [3:0] l, input logic [1:0] f);
    return {2'b01, l[3], f[0], f[1], l[2:0]};
  endfunction
  initial begin
    {rst_n, power_up_preset, psel, penable, pwrite, mem_valid, clr_seen} = 7'h00;
    {accumulating_flag, dead_time_overrun, sync_error_full, count_done, power_fail} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mem_data = 8'h00;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    void'($urandom(32'h41fa));
    fill0 = 2'($urandom_range(2));
    mem_fill = fill0;
    addr_switch = 7'($urandom_range(63));
    // All ones would turn the listen address into unlisten
    if (addr_switch[4:1] == 4'hf) addr_switch[1] = 1'b0;
    codes = '{`IIC_PC_MANT, `IIC_PC_DEAD, `IIC_PC_EXP, `IIC_PC_TRIG, `IIC_PC_COUNT, `IIC_PC_DIGIT};
    cmd = '{`IIC_PC_CLEAR, `IIC_PC_HALT, 8'ha0 + 8'($urandom_range(95)), `IIC_CMD_GET,
      `IIC_CMD_SDC, `IIC_CMD_DCL};
    want = '{9'h0f8, 9'h008, 9'h100, 9'h004, 9'h002, 9'h002};
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk({listen_ind, srq_n_oe, serial_poll_active, stb}, 0);
    chk(trig_level_4v, addr_switch[5]);
    apb(1'b0, `IIC_A_STAT, 0);
    chk(rd, {26'h0, mem_fill, 4'h0});
    apb(1'b0, 12'h00c, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b1, `IIC_A_CTRL, 32'h0000_0001);
    apb(1'b0, `IIC_A_CTRL, 0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, `IIC_A_CTRL, 0);
    v = {3'b001, addr_switch[4:1], 1'($urandom)};
    ctl.send(1'b1, v, ok);
    repeat (4) @(negedge clk_sys);
    chk({ok, listen_ind}, 2'b11);
    for (k = 0; k < 6; k++) begin
      b = 8'h30 + 8'($urandom_range(9));
      ctl.send(1'b0, codes[k], ok);
      ctl.send(1'b0, b, ok);
      wait_stb(k);
      chk(programmed_data_lines[3:0], b[3:0]);
    end
    for (k = 0; k < 6; k++) begin
      @(posedge clk_sys) clr_seen <= 1'b1;
      @(posedge clk_sys) clr_seen <= 1'b0;
      ctl.send(k > 2, cmd[k], ok);
      repeat (4) @(negedge clk_sys);
      chk(seen & (k < 3 ? 9'h1ff : 9'h006), want[k]);
      if (k == 2) chk(programmed_data_lines, cmd[2]);
    end
    for (k = 0; k < 3; k++) begin
      @(posedge clk_sys) accumulating_flag <= (k == 0);
      mem_fill <= (k == 1) ? 2'h3 : fill0;
      if (k == 2) apb(1'b1, `IIC_A_CTRL, 32'h0000_0001);
      ctl.send(1'b0, 8'hc3, ok);
      chk(ok, 1'b0);
    end
    apb(1'b1, `IIC_A_CTRL, 0);
    ctl.send(1'b0, 8'hc3, ok);
    chk(ok, 1'b1);
    lat = 4'($urandom_range(15, 1));
    @(posedge clk_sys) {count_done, sync_error_full, dead_time_overrun, power_fail} <= lat;
    @(posedge clk_sys) {count_done, sync_error_full, dead_time_overrun, power_fail} <= 4'h0;
    repeat (2) @(negedge clk_sys);
    chk({service_request_out, srq_n_oe}, 2'b11);
    apb(1'b0, `IIC_A_STAT, 0);
    chk(rd, {22'h0, 4'h2, mem_fill, lat});
    ctl.send(1'b1, `IIC_CMD_UNL, ok);
    ctl.send(1'b1, {3'b010, addr_switch[4:1], 1'b0}, ok);
    ctl.send(1'b1, `IIC_CMD_SPE, ok);
    repeat (4) @(negedge clk_sys);
    chk({serial_poll_active, talk_ind}, 2'b11);
    ctl.recv(0, b, ok);
    chk(b, sbyte(lat, mem_fill));
    repeat (4) @(negedge clk_sys);
    chk(service_request_out, 1'b0);
    ctl.send(1'b1, `IIC_CMD_SPD, ok);
    repeat (4) @(negedge clk_sys);
    chk(serial_poll_active, 1'b0);
    for (k = 0; k < 2; k++) begin
      @(posedge clk_sys) mem_data <= 8'($urandom);
      mem_valid <= 1'b1;
      clr_seen <= 1'b1;
      @(posedge clk_sys) clr_seen <= 1'b0;
      ctl.recv(k * 300, b, ok);
      mem_valid <= 1'b0;
      @(negedge clk_sys);
      chk({b, seen[0]}, {mem_data, 1'b1});
    end
    ctl.send(1'b1, `IIC_CMD_UNT, ok);
    chk(talk_ind, 1'b0);
    @(posedge clk_sys) addr_switch[6] <= 1'b1;
    @(negedge clk_sys);
    chk(talk_ind, 1'b1);
    @(posedge clk_sys) addr_switch[6] <= 1'b0;
    ctl.send(1'b1, v, ok);
    @(posedge clk_sys) power_up_preset <= 1'b1;
    @(posedge clk_sys) power_up_preset <= 1'b0;
    @(negedge clk_sys);
    chk(listen_ind, 1'b0);
    stop_test();
  end
endmodule
